// *** dv/cku_checker.sv ***
// port checker for the checksum unit
// assumes a bind onto cku_top
`timescale 1ns/1ps
`default_nettype none
module cku_checker (
	input wire logic clock,
	input wire logic rst,
	input wire cku_pkg::cku_sfr_req_type sfr_req,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_rvalid,
	input wire logic input_ready,
	input wire logic busy
);
	import cku_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// mirror of a byte
	function automatic logic [7:0] rev(input logic [7:0] d);
		for (int i = 0; i < 8; i++) rev[i] = d[7-i];
	endfunction
	// one register access
	sequence s_wr(a); sfr_req.wr && sfr_req.addr == a; endsequence
	sequence s_rd(a); sfr_req.rd && sfr_req.addr == a; endsequence
	property p_rv; sfr_req.rd |=> sfr_rvalid; endproperty
	a_rv: assert property (p_rv) else $error("read not answered");
	property p_norv; !sfr_req.rd |=> !sfr_rvalid; endproperty
	a_norv: assert property (p_norv) else $error("stray read valid");
	property p_ctl; s_wr(8'h84) ##1 s_rd(8'h84) |=> sfr_rdata ==
		{3'h0, $past(sfr_req.wdata[4], 2), 1'b0, $past(sfr_req.wdata[2:0], 2)}; endproperty
	a_ctl: assert property (p_ctl) else $error("control readback");
	property p_flip; s_wr(8'h87) ##1 s_rd(8'h87) |=> sfr_rdata == rev($past(sfr_req.wdata, 2));
	endproperty
	a_flip: assert property (p_flip) else $error("mirror readback");
	property p_in0; s_rd(8'h85) |=> sfr_rdata == 8'h00; endproperty
	a_in0: assert property (p_in0) else $error("input reg read");
	// reset is checked while reset is active, so no disable here
	property p_rst; disable iff (1'b0) rst |=> input_ready && !busy && !sfr_rvalid; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_busy; s_wr(8'h85) ##0 input_ready |-> ##2 busy; endproperty
	a_busy: assert property (p_busy) else $error("fold late");
	property p_rose; $rose(busy) |-> $past(sfr_req.wr && sfr_req.addr == 8'h85, 2); endproperty
	a_rose: assert property (p_rose) else $error("fold uncaused");
endmodule
bind cku_top cku_checker cku_checker_i (.clock(clock), .rst(rst), .sfr_req(sfr_req),
	.sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .input_ready(input_ready), .busy(busy));
`default_nettype wire

// *** dv/cku_top_tb_top.sv ***
// self-checking bench for the checksum unit
// assumes cku_top and the bound checker
`timescale 1ns/1ps
`default_nettype none
module cku_top_tb_top;
	import cku_pkg::*;
	logic clock = 0;
	logic rst = 1;
	logic rdy, busy, rv;
	logic [7:0] rdata;
	cku_sfr_req_type req = '0;
	logic [7:0] q[$]; // expected read bytes
	logic [31:0] m; // reference result
	int failures = 0;
	int check_count = 0;
	always #25 clock = ~clock;
	cku_top #(.FIFO_DEPTH(16)) cku_top_i (.clock(clock), .rst(rst), .sfr_req(req),
		.sfr_rdata(rdata), .sfr_rvalid(rv), .input_ready(rdy), .busy(busy));
	task complete_run;
		if (failures == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("Error %0t read %h want %h", $time, s, e);
		end
	endtask
	// one access, held for one rising edge
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		req = '{w, !w, a, d};
		@(negedge clock);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		q.push_back(e);
		acc(0, a, 8'h00);
	endtask
	// msb-first fold, no reflection
	function automatic logic [31:0] fold(input logic [31:0] c, input logic [7:0] b, input logic s);
		for (int i = 7; i >= 0; i--) begin
			if (s) c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i]) ? 32'h04C11DB7 : 32'h0);
			else c = {16'h0, c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 32'h1021 : 32'h0);
		end
		return c;
	endfunction
	// watcher side: oldest note against each answer
	always @(negedge clock) if (rv === 1'b1) chk(rdata, q.pop_front());
	initial begin
		#(4000 * 50);
		failures++;
		complete_run;
	end
	initial begin
		logic [7:0] d;
		logic [7:0] c;
		void'($urandom(32'hAB13A7EE));
		repeat (4) @(negedge clock);
		rst = 0;
		rd(8'h84, 8'h00);
		rd(8'h85, 8'h00);
		for (int i = 0; i < 4; i++) begin
			d = $urandom;
			acc(1, 8'h87, d);
			rd(8'h87, {<<{d}});
		end
		// every width and preset pairing
		for (int k = 0; k < 4; k++) begin
			c = {3'h0, k[1], 1'b1, k[0], 2'h0};
			acc(1, 8'h84, c);
			rd(8'h84, c & 8'h17);
			m = k[0] ? 32'hFFFFFFFF : 32'h0;
			for (int i = 0; i < 5; i++) begin
				d = $urandom;
				acc(1, 8'h85, d);
				m = fold(m, d, k[1]);
			end
			req = '0;
			repeat (2) @(negedge clock);
			for (int j = 0; j < 40 && busy !== 1'b0; j++) @(negedge clock);
			for (int p = 0; p < 4; p++) begin
				acc(1, 8'h84, {c[7:4], 1'b0, c[2], p[1:0]});
				rd(8'h86, k[1] ? m[8*p+:8] : m[8*p[0]+:8]);
			end
			d = $urandom;
			acc(1, 8'h86, d);
			rd(8'h86, d);
		end
		req = '0;
		chk({7'h00, rdy}, 8'h01);
		// mid-run reset: control and result must read back their reset values
		rst = 1;
		repeat (2) @(negedge clock);
		rst = 0;
		rd(8'h84, 8'h00);
		rd(8'h86, 8'h00);
		req = '0;
		repeat (3) @(negedge clock);
		chk(8'(q.size()), 8'h00);
		complete_run;
	end
endmodule
`default_nettype wire

// *** verilog/cku_cfg.svh ***
// checksum unit constants: register offsets, field positions, presets
// assumes inclusion from the top module only
`ifndef CKU_CFG_SVH
`define CKU_CFG_SVH
`define CKU_OFS_CONTROL 8'h84
`define CKU_OFS_INPUT 8'h85
`define CKU_OFS_RESULT 8'h86
`define CKU_OFS_FLIP 8'h87
`define CKU_BIT_PNT_LO 0
`define CKU_BIT_VAL 2
`define CKU_BIT_INIT 3
`define CKU_BIT_SEL 4
`define CKU_CONTROL_RESET 8'h00
`define CKU_POLY16 16'h1021
`define CKU_POLY32 32'h04C11DB7
`define CKU_PRESET_ZERO 32'h00000000
`define CKU_PRESET_ONES 32'hFFFFFFFF
`endif

// *** verilog/cku_fifo.sv ***
// byte fifo between the input register and the checksum engine
// assumes one clock, synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module cku_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("cku_fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH]; // storage
	logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr; // extra bit tells full from empty
	logic push, pop;
	// honest flags from the pointers
	always_comb begin
		in_ready = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
		out_valid = wr_ptr != rd_ptr;
		out_data = mem[rd_ptr[AW-1:0]];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = wr_ptr + (AW+1)'(push);
		next_rd_ptr = rd_ptr + (AW+1)'(pop);
	end
	// pointers and storage
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end
endmodule
`default_nettype wire

// *** verilog/cku_pkg.sv ***
// checksum unit types shared by the design
// assumes nothing beyond the config header
package cku_pkg;
	// one register access from the special-function register port
	typedef struct packed {
		logic wr; // write strobe
		logic rd; // read strobe
		logic [7:0] addr; // register address
		logic [7:0] wdata; // write data
	} cku_sfr_req_type;
	// drain side states of the byte engine
	typedef enum logic [1:0] {
		CKU_IDLE = 2'b01,
		CKU_FOLD = 2'b10
	} cku_state_type;
endpackage

// *** verilog/cku_top.sv ***
// checksum unit on the special-function register port
// assumes single byte accesses, one per cycle, synchronous to clock
// Function
// - select 0x1021 or 0x04C11DB7 generator
// - result width 16 or 32 bits
// - preset select chooses zeros or ones
// - each input byte folds into result
// - pointer selects result byte for access
// - 16-bit mode pointer bit1 ignored
// - 32-bit mode pointer picks four bytes
// - result holds until set, written, fed
// - bit-reverse register reads back mirrored
`include "cku_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cku_top #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clock,
	input wire logic rst,
	input wire cku_pkg::cku_sfr_req_type sfr_req,
	output logic [7:0] sfr_rdata,
	output logic sfr_rvalid,
	output logic input_ready,
	output logic busy
);
	import cku_pkg::*;
	logic [7:0] control, next_control; // sel, val, pointer; init bit never stored
	logic [31:0] result, next_result; // running checksum
	logic [7:0] flip, next_flip; // bit-reverse holding byte
	logic [7:0] next_rdata;
	logic next_rvalid, next_busy, next_input_ready;
	cku_state_type state, next_state;
	logic wr_ctl, wr_in, wr_dat, wr_flip, rd_dat;
	logic f_valid, f_ready, f_in_ready;
	logic [7:0] f_data;
	logic [1:0] pnt_eff; // pointer after width masking
	logic [31:0] folded;
	// fifo keeps back-to-back input writes while the engine folds
	cku_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.rst(rst),
		.in_valid(wr_in),
		.in_ready(f_in_ready),
		.in_data(sfr_req.wdata),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data)
	);
	// fold one byte msb first through 16 or 32 bit generator
	function automatic logic [31:0] fold_byte(input logic [31:0] cur, input logic [7:0] b,
		input logic wide);
		logic [31:0] c;
		logic fb;
		c = cur;
		for (int i = 7; i >= 0; i--) begin
			if (wide) begin
				fb = c[31] ^ b[i];
				c = {c[30:0], 1'b0} ^ (fb ? `CKU_POLY32 : 32'h0);
			end else begin
				fb = c[15] ^ b[i];
				c = {16'h0, c[14:0], 1'b0} ^ (fb ? {16'h0, `CKU_POLY16} : 32'h0);
			end
		end
		return c;
	endfunction
	// address decode and next values
	always_comb begin
		wr_ctl = sfr_req.wr && sfr_req.addr == `CKU_OFS_CONTROL;
		wr_in = sfr_req.wr && sfr_req.addr == `CKU_OFS_INPUT;
		wr_dat = sfr_req.wr && sfr_req.addr == `CKU_OFS_RESULT;
		wr_flip = sfr_req.wr && sfr_req.addr == `CKU_OFS_FLIP;
		rd_dat = sfr_req.rd && sfr_req.addr == `CKU_OFS_RESULT;
		// narrow mode ignores the upper pointer bit
		pnt_eff = control[`CKU_BIT_SEL] ? control[1:0] : {1'b0, control[0]};
		f_ready = 1'b1; // engine takes one byte per clock
		folded = fold_byte(result, f_data, control[`CKU_BIT_SEL]);
		next_control = control;
		next_result = result;
		next_flip = flip;
		next_state = f_valid ? CKU_FOLD : CKU_IDLE;
		if (f_valid)
			next_result = folded;
		if (wr_dat)
			next_result[pnt_eff*8 +: 8] = sfr_req.wdata;
		if (wr_ctl) begin
			next_control = {3'b000, sfr_req.wdata[4], 1'b0, sfr_req.wdata[2:0]};
			// init uses the preset being written now, matching step order
			if (sfr_req.wdata[`CKU_BIT_INIT])
				next_result = sfr_req.wdata[`CKU_BIT_VAL] ? `CKU_PRESET_ONES
					: `CKU_PRESET_ZERO;
		end
		if (wr_flip)
			next_flip = {<<{sfr_req.wdata}};
		next_rvalid = sfr_req.rd;
		next_rdata = 8'h00; // unmapped and write-only read zero
		if (sfr_req.rd) begin
			unique case (sfr_req.addr)
				`CKU_OFS_CONTROL: next_rdata = control;
				`CKU_OFS_RESULT: next_rdata = result[pnt_eff*8 +: 8];
				`CKU_OFS_FLIP: next_rdata = flip;
				default: next_rdata = 8'h00;
			endcase
		end
		next_busy = f_valid;
		next_input_ready = f_in_ready;
	end
	// register stage; outputs all from flops
	always_ff @(posedge clock) begin
		if (rst) begin
			control <= `CKU_CONTROL_RESET;
			result <= `CKU_PRESET_ZERO;
			flip <= 8'h00;
			state <= CKU_IDLE;
			sfr_rdata <= 8'h00;
			sfr_rvalid <= 1'b0;
			busy <= 1'b0;
			input_ready <= 1'b1;
		end else begin
			control <= next_control;
			result <= next_result;
			flip <= next_flip;
			state <= next_state;
			sfr_rdata <= next_rdata;
			sfr_rvalid <= next_rvalid;
			busy <= next_busy;
			input_ready <= next_input_ready;
		end
	end
	logic unused_rd_dat;
	assign unused_rd_dat = rd_dat ^ (state == CKU_FOLD);
endmodule
`default_nettype wire
